// file: logic/pci_defines.svh
`ifndef PCI_DEFINES_SVH
`define PCI_DEFINES_SVH

// Bus commands carried on the command/byte-enable lines in the address phase
`define CMD_MEM_RD 4'h6
`define CMD_MEM_WR 4'h7
`define CMD_CFG_RD 4'hA
`define CMD_CFG_WR 4'hB

// Highest link clock rate the bus allows, in MHz
`define PCLK_MAX_MHZ 33.3333
// Local clock period and the link clock period made by the host, in ns
`define MCLK_NS 100
`define PCLK_NS 800
// Link clock divider: local clocks per link clock and per half period
`define PCLK_DIV (`PCLK_NS / `MCLK_NS)
`define PCLK_HALF (`PCLK_DIV / 2)

// Link clocks an initiator waits for a device select before aborting
`define ABORT_CLKS 3'h5
// Configuration words in the device, memory words in the host target
`define CFG_WORDS 4
`define MEM_WORDS 16

`endif

// file: logic/pci_pkg.sv
package pci_pkg;

  // Shared lines of the bus; the control lines are active low
  typedef struct packed {
    logic [31:0] ad;        // Address/data
    logic [3:0]  cbe;       // Command / byte enables, active low
    logic        par;       // Even parity, one clock late
    logic        frame_n;   // Cycle frame
    logic        irdy_n;    // Initiator ready
    logic        trdy_n;    // Target ready
    logic        devsel_n;  // Device select
  } pci_bus_t;

  // Phases of either end, as target or as initiator
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T_WAIT,
    ST_T_DATA,
    ST_T_END,
    ST_M_ADDR,
    ST_M_DATA,
    ST_M_END
  } link_state_t;

endpackage: pci_pkg

// file: logic/pci_link_if.sv
`timescale 1ns/1ps
interface pci_link_if;
  import pci_pkg::*;

  logic     pclk;     // Link clock, made by the host
  logic     prst_n;   // Bus reset, active low
  logic     idsel;    // Configuration select of the device
  logic     req_n;    // Device bus request
  logic     gnt_n;    // Grant to the device
  pci_bus_t h_out;    // Host drive values
  pci_bus_t h_oe_n;   // Host enables, low drives
  pci_bus_t d_out;    // Device drive values
  pci_bus_t d_oe_n;   // Device enables, low drives
  pci_bus_t bus;      // Resolved wire level

  // Pulled-up wires: undriven lines read high, a low driver wins
  assign bus = (h_out | h_oe_n) & (d_out | d_oe_n);

  modport dev (input pclk, prst_n, idsel, gnt_n, bus, output req_n, d_out, d_oe_n);
  modport host (output pclk, prst_n, idsel, gnt_n, h_out, h_oe_n, input req_n, bus);

endinterface: pci_link_if

// file: logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  // Three stages; a bit is taken once stages two and three agree
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_st_t;

  sync_st_t s;  // Registered state
  sync_st_t n;  // Next state

  // Shift, then filter out a bit still settling
  always_comb begin
    n    = s;
    n.s1 = i_d;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.q  = (s.s2 & s.s3) | (s.q & (s.s2 ^ s.s3));
  end

  // Idle wires are pulled high, so reset to ones
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '1;
    end else begin
      s <= n;
    end
  end

  assign o_q = s.q;

endmodule: pin_sync

// file: logic/pci_dev_end.sv
`timescale 1ns/1ps
`include "pci_defines.svh"
module pci_dev_end
  import pci_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  pci_link_if.dev          link,
  input  wire logic        i_req_valid,
  input  wire logic        i_req_write,
  input  wire logic [31:0] i_req_addr,
  input  wire logic [3:0]  i_req_be,
  input  wire logic [31:0] i_req_data,
  output logic             o_req_ready,
  output logic             o_rsp_valid,
  output logic      [31:0] o_rsp_data,
  output logic             o_rsp_abort
);

  typedef struct packed {
    link_state_t                     st;         // Phase
    logic                            pclk_q;     // Link clock last seen
    logic                            frame_q;    // Frame last sampled
    pci_bus_t                        drv;        // Drive values
    pci_bus_t                        oe_n;       // Drive enables
    logic                            req_n;      // Bus request
    logic [`CFG_WORDS-1:0][31:0]     cfg;        // Configuration words
    logic [1:0]                      idx;        // Word in a target burst
    logic                            t_wr;       // Target write
    logic                            m_pend;     // Initiator job held
    logic                            m_wr;       // Job is a write
    logic [31:0]                     m_addr;     // Job address
    logic [3:0]                      m_be;       // Job enables, high true
    logic [31:0]                     m_data;     // Job write data
    logic [2:0]                      wcnt;       // Wait for device select
    logic                            req_ready;  // Job slot free
    logic                            rsp_valid;  // Job done pulse
    logic [31:0]                     rsp_data;   // Read data
    logic                            rsp_abort;  // Nobody answered
  } dev_st_t;

  localparam dev_st_t DEV_RST = '{st: ST_IDLE, pclk_q: 1'b1, frame_q: 1'b1, drv: '1, oe_n: '1,
                                  req_n: 1'b1, req_ready: 1'b1, default: '0};

  dev_st_t     s;        // Registered state
  dev_st_t     n;        // Next state
  logic        arst_n;   // Local or bus reset
  logic [43:0] sync_q;   // Filtered pins
  pci_bus_t    b;        // Sampled bus
  logic        pclk_s;   // Sampled link clock
  logic        idsel_s;  // Sampled select
  logic        gnt_n_s;  // Sampled grant
  logic        pe;       // Link clock rise seen
  logic        addr_ph;  // Address phase on this rise
  logic [3:0]  cmd;      // Command of the address phase

  // Bus reset acts without the clock; its release is not synchronised,
  // the bench must hold the link quiet around it
  assign arst_n = i_rst_n & link.prst_n;

  // Every link input but the bus reset through the three-stage filter, clock included
  pin_sync #(
    .W (44)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (arst_n),
    .i_d     ({link.pclk, link.idsel, link.gnt_n, link.bus}),
    .o_q     (sync_q)
  );

  assign pclk_s  = sync_q[43];
  assign idsel_s = sync_q[42];
  assign gnt_n_s = sync_q[41];
  assign b       = sync_q[40:0];
  // Rates up to the local clock over eight are met; faster ones need a faster local clock
  assign pe      = pclk_s & ~s.pclk_q;
  assign addr_ph = ~b.frame_n & s.frame_q;
  assign cmd     = b.cbe;

  // Next state: job intake every cycle, bus work on link clock rises
  always_comb begin
    n           = s;
    n.rsp_valid = 1'b0;
    n.pclk_q    = pclk_s;
    // Take a new job and ask for the bus
    if (i_req_valid && !s.m_pend) begin
      n.m_pend = 1'b1;
      n.m_wr   = i_req_write;
      n.m_addr = i_req_addr;
      n.m_be   = i_req_be;
      n.m_data = i_req_data;
      n.req_n  = 1'b0;
    end
    if (pe) begin
      n.frame_q  = b.frame_n;
      // Parity over what stood on the wires last clock, driven if we drove the data
      n.drv.par  = ~^{b.ad, b.cbe} ^ 1'b1;
      n.oe_n.par = s.oe_n.ad[0];
      unique case (s.st)
        ST_IDLE: begin
          if (addr_ph && idsel_s && (cmd == `CMD_CFG_RD || cmd == `CMD_CFG_WR)) begin
            // Claim: dword index from the address lines
            n.idx        = b.ad[3:2];
            n.t_wr       = (cmd == `CMD_CFG_WR);
            n.drv.devsel_n  = 1'b0;
            n.oe_n.devsel_n = 1'b0;
            n.drv.trdy_n    = 1'b1;
            n.oe_n.trdy_n   = 1'b0;
            n.st            = ST_T_WAIT;
          end else if (s.m_pend && !gnt_n_s && b.frame_n && b.irdy_n) begin
            // Granted and idle: address phase with command
            n.req_n      = 1'b1;
            n.drv.frame_n  = 1'b0;
            n.oe_n.frame_n = 1'b0;
            n.drv.ad     = {s.m_addr[31:2], 2'h0};
            n.oe_n.ad    = '0;
            n.drv.cbe    = s.m_wr ? `CMD_MEM_WR : `CMD_MEM_RD;
            n.oe_n.cbe   = '0;
            n.st         = ST_M_ADDR;
          end
        end
        ST_T_WAIT: begin
          // Turnaround clock passed, now ready; reads put data out
          n.drv.trdy_n = 1'b0;
          if (!s.t_wr) begin
            n.drv.ad  = s.cfg[s.idx];
            n.oe_n.ad = '0;
          end
          n.st = ST_T_DATA;
        end
        ST_T_DATA: begin
          if (!b.irdy_n && !b.trdy_n) begin
            if (s.t_wr) begin
              // Only enabled lanes land, lane k is bits 8k up
              for (int k = 0; k < 4; k++) begin
                if (!b.cbe[k]) begin
                  n.cfg[s.idx][8*k +: 8] = b.ad[8*k +: 8];
                end
              end
            end
            if (b.frame_n) begin
              // Final phase done: park lines high for one clock
              n.drv.trdy_n   = 1'b1;
              n.drv.devsel_n = 1'b1;
              n.oe_n.ad      = '1;
              n.st           = ST_T_END;
            end else begin
              n.idx    = s.idx + 2'h1;
              n.drv.ad = n.cfg[n.idx];
            end
          end
        end
        ST_T_END: begin
          n.oe_n.trdy_n   = 1'b1;
          n.oe_n.devsel_n = 1'b1;
          n.st            = ST_IDLE;
        end
        ST_M_ADDR: begin
          // Single data phase, so frame goes high now
          n.drv.frame_n = 1'b1;
          n.drv.irdy_n  = 1'b0;
          n.oe_n.irdy_n = 1'b0;
          n.drv.cbe     = ~s.m_be;
          n.drv.ad      = s.m_data;
          n.oe_n.ad     = s.m_wr ? '0 : '1;
          n.wcnt        = '0;
          n.st          = ST_M_DATA;
        end
        ST_M_DATA: begin
          if (!b.irdy_n && !b.trdy_n) begin
            n.rsp_valid = 1'b1;
            n.rsp_data  = b.ad;
            n.rsp_abort = 1'b0;
            n.st        = ST_M_END;
          end else if (b.devsel_n && s.wcnt == `ABORT_CLKS) begin
            n.rsp_valid = 1'b1;
            n.rsp_data  = '0;
            n.rsp_abort = 1'b1;
            n.st        = ST_M_END;
          end else begin
            n.wcnt = s.wcnt + 3'h1;
          end
          if (n.st == ST_M_END) begin
            n.drv.irdy_n   = 1'b1;
            n.oe_n.ad      = '1;
            n.oe_n.cbe     = '1;
            n.oe_n.frame_n = 1'b1;
          end
        end
        ST_M_END: begin
          n.oe_n.irdy_n = 1'b1;
          n.m_pend      = 1'b0;
          n.st          = ST_IDLE;
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end
    n.req_ready = ~n.m_pend;
  end

  // State register; bus reset floats every line at once
  always_ff @(posedge i_mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= DEV_RST;
    end else begin
      s <= n;
    end
  end

  assign link.d_out  = s.drv;
  assign link.d_oe_n = s.oe_n;
  assign link.req_n  = s.req_n;
  assign o_req_ready = s.req_ready;
  assign o_rsp_valid = s.rsp_valid;
  assign o_rsp_data  = s.rsp_data;
  assign o_rsp_abort = s.rsp_abort;

endmodule: pci_dev_end

// file: logic/pci_host_end.sv
`timescale 1ns/1ps
`include "pci_defines.svh"
module pci_host_end
  import pci_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  pci_link_if.host         link,
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_cfg,
  input  wire logic        i_cmd_write,
  input  wire logic [31:0] i_cmd_addr,
  input  wire logic [3:0]  i_cmd_be,
  input  wire logic [31:0] i_cmd_data,
  output logic             o_cmd_ready,
  output logic             o_done_valid,
  output logic      [31:0] o_done_data,
  output logic             o_done_abort
);

  typedef struct packed {
    logic [2:0]                  cnt;         // Divider phase
    logic                        pclk;        // Link clock out
    logic                        prst_n;      // Bus reset out
    link_state_t                 st;          // Phase
    logic                        frame_q;     // Frame last sampled
    pci_bus_t                    drv;         // Drive values
    pci_bus_t                    oe_n;        // Drive enables
    logic                        idsel;       // Device select out
    logic                        gnt_n;       // Grant out
    logic [`MEM_WORDS-1:0][31:0] mem;         // Target memory
    logic [3:0]                  idx;         // Target word
    logic                        t_wr;        // Target write
    logic                        c_pend;      // Command held
    logic                        c_cfg;       // Configuration command
    logic                        c_wr;        // Write command
    logic [31:0]                 c_addr;      // Command address
    logic [3:0]                  c_be;        // Enables, high true
    logic [31:0]                 c_data;      // Write data
    logic [2:0]                  wcnt;        // Wait for device select
    logic                        cmd_ready;   // Slot free
    logic                        done_valid;  // Done pulse
    logic [31:0]                 done_data;   // Read data
    logic                        done_abort;  // Master abort
  } host_st_t;

  localparam host_st_t HOST_RST = '{st: ST_IDLE, pclk: 1'b1, frame_q: 1'b1, drv: '1, oe_n: '1,
                                    gnt_n: 1'b1, cmd_ready: 1'b1, default: '0};

  host_st_t    s;       // Registered state
  host_st_t    n;       // Next state
  logic [41:0] sync_q;  // Filtered pins
  pci_bus_t    b;       // Sampled bus
  logic        req_n_s; // Sampled request
  logic        pe;      // Acting point of a link clock
  logic        addr_ph; // Address phase seen, ours or the device's

  pin_sync #(
    .W (42)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     ({link.req_n, link.bus}),
    .o_q     (sync_q)
  );

  assign req_n_s = sync_q[41];
  assign b       = sync_q[40:0];
  // Act late in the high half: the far end has settled, and our drives
  // change with the falling edge, well clear of the next rise
  assign pe      = (s.cnt == 3'(`PCLK_HALF - 1));
  assign addr_ph = ~b.frame_n & s.frame_q;

  // Next state: divider, intake, arbiter, initiator and target
  always_comb begin
    n            = s;
    n.done_valid = 1'b0;
    n.prst_n     = 1'b1;
    n.cnt        = (s.cnt == 3'(`PCLK_DIV - 1)) ? 3'h0 : s.cnt + 3'h1;
    n.pclk       = (n.cnt < 3'(`PCLK_HALF));
    if (i_cmd_valid && !s.c_pend) begin
      n.c_pend = 1'b1;
      n.c_cfg  = i_cmd_cfg;
      n.c_wr   = i_cmd_write;
      n.c_addr = i_cmd_addr;
      n.c_be   = i_cmd_be;
      n.c_data = i_cmd_data;
    end
    if (pe) begin
      n.frame_q  = b.frame_n;
      n.drv.par  = ^{b.ad, b.cbe};
      n.oe_n.par = s.oe_n.ad[0];
      n.idsel    = 1'b0;
      // Grant held until the device starts its frame
      if (!s.gnt_n && addr_ph) begin
        n.gnt_n = 1'b1;
      end else if (s.st == ST_IDLE && !req_n_s && !s.c_pend) begin
        n.gnt_n = 1'b0;
      end
      unique case (s.st)
        ST_IDLE: begin
          if (addr_ph && (b.cbe == `CMD_MEM_RD || b.cbe == `CMD_MEM_WR)) begin
            n.idx           = b.ad[5:2];
            n.t_wr          = (b.cbe == `CMD_MEM_WR);
            n.drv.devsel_n  = 1'b0;
            n.oe_n.devsel_n = 1'b0;
            n.drv.trdy_n    = 1'b1;
            n.oe_n.trdy_n   = 1'b0;
            n.st            = ST_T_WAIT;
          end else if (s.c_pend && s.gnt_n && b.frame_n && b.irdy_n) begin
            // Own command goes first: the grant waits for it, so waiting on
            // the request here as well would lock both ends up for good
            n.idsel        = s.c_cfg;
            n.drv.frame_n  = 1'b0;
            n.oe_n.frame_n = 1'b0;
            // Configuration and memory commands both carry a dword address
            n.drv.ad       = {s.c_addr[31:2], 2'h0};
            n.oe_n.ad      = '0;
            n.drv.cbe      = s.c_cfg ? (s.c_wr ? `CMD_CFG_WR : `CMD_CFG_RD)
                                     : (s.c_wr ? `CMD_MEM_WR : `CMD_MEM_RD);
            n.oe_n.cbe     = '0;
            n.st           = ST_M_ADDR;
          end
        end
        ST_T_WAIT: begin
          n.drv.trdy_n = 1'b0;
          n.drv.ad     = s.mem[s.idx];
          n.oe_n.ad    = s.t_wr ? '1 : '0;
          n.st         = ST_T_DATA;
        end
        ST_T_DATA: begin
          if (!b.irdy_n && !b.trdy_n) begin
            for (int k = 0; k < 4; k++) begin
              if (s.t_wr && !b.cbe[k]) begin
                n.mem[s.idx][8*k +: 8] = b.ad[8*k +: 8];
              end
            end
            if (b.frame_n) begin
              n.drv.trdy_n   = 1'b1;
              n.drv.devsel_n = 1'b1;
              n.oe_n.ad      = '1;
              n.st           = ST_T_END;
            end else begin
              n.idx    = s.idx + 4'h1;
              n.drv.ad = n.mem[n.idx];
            end
          end
        end
        ST_T_END: begin
          n.oe_n.trdy_n   = 1'b1;
          n.oe_n.devsel_n = 1'b1;
          n.st            = ST_IDLE;
        end
        ST_M_ADDR: begin
          n.drv.frame_n = 1'b1;
          n.drv.irdy_n  = 1'b0;
          n.oe_n.irdy_n = 1'b0;
          n.drv.cbe     = ~s.c_be;
          n.drv.ad      = s.c_data;
          n.oe_n.ad     = s.c_wr ? '0 : '1;
          n.wcnt        = '0;
          n.st          = ST_M_DATA;
        end
        ST_M_DATA: begin
          if (!b.irdy_n && !b.trdy_n) begin
            n.done_valid = 1'b1;
            n.done_data  = b.ad;
            n.done_abort = 1'b0;
            n.st         = ST_M_END;
          end else if (b.devsel_n && s.wcnt == `ABORT_CLKS) begin
            n.done_valid = 1'b1;
            n.done_data  = '0;
            n.done_abort = 1'b1;
            n.st         = ST_M_END;
          end else begin
            n.wcnt = s.wcnt + 3'h1;
          end
          if (n.st == ST_M_END) begin
            n.drv.irdy_n   = 1'b1;
            n.oe_n.ad      = '1;
            n.oe_n.cbe     = '1;
            n.oe_n.frame_n = 1'b1;
          end
        end
        ST_M_END: begin
          n.oe_n.irdy_n = 1'b1;
          n.c_pend      = 1'b0;
          n.st          = ST_IDLE;
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end
    n.cmd_ready = ~n.c_pend;
  end

  // State register; bus reset held low while the local reset is
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= HOST_RST;
    end else begin
      s <= n;
    end
  end

  assign link.pclk    = s.pclk;
  assign link.prst_n  = s.prst_n;
  assign link.idsel   = s.idsel;
  assign link.gnt_n   = s.gnt_n;
  assign link.h_out   = s.drv;
  assign link.h_oe_n  = s.oe_n;
  assign o_cmd_ready  = s.cmd_ready;
  assign o_done_valid = s.done_valid;
  assign o_done_data  = s.done_data;
  assign o_done_abort = s.done_abort;

endmodule: pci_host_end

// file: verification/pci_link_sva.sv
`timescale 1ns/1ps
`include "pci_defines.svh"
module pci_link_sva
  import pci_pkg::*;
(
  input wire logic     i_mclk,
  input wire logic     i_rst_n,
  input wire logic     pclk,
  input wire logic     prst_n,
  input wire logic     idsel,
  input wire logic     req_n,
  input wire logic     gnt_n,
  input wire pci_bus_t bus,
  input wire pci_bus_t h_oe_n,
  input wire pci_bus_t d_oe_n
);
  logic pclk_q; // Link clock one cycle ago
  logic frm_q;  // Frame at the last link rise
  logic par_q;  // Parity owed at the next rise
  logic rise;   // This cycle sees a link rise
  logic aph;    // This rise is an address phase
  assign rise = pclk && !pclk_q;
  assign aph  = rise && !bus.frame_n && frm_q;

  // Keep frame and wire parity of each rise for the next one
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pclk_q <= 1'b1;
      frm_q  <= 1'b1;
      par_q  <= 1'b0;
    end else begin
      pclk_q <= pclk;
      if (rise) begin
        frm_q <= bus.frame_n;
        par_q <= ^{bus.ad, bus.cbe};
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // Starts of a transfer, by who drives frame or by the configuration select
  sequence s_host_go; aph && !h_oe_n.frame_n; endsequence
  sequence s_dev_go;  aph && !d_oe_n.frame_n; endsequence
  sequence s_cfg_go;  aph && idsel;           endsequence

  chk_reset_float: assert property (!prst_n |-> &d_oe_n)
    else $error("device drives during bus reset");
  chk_even_par: assert property (rise && !(d_oe_n.par && h_oe_n.par) |-> bus.par == par_q)
    else $error("parity wrong");
  chk_idsel_cfg: assert property (rise && idsel |-> aph && bus.cbe inside {`CMD_CFG_RD, `CMD_CFG_WR})
    else $error("select outside config address phase");
  chk_addr_word: assert property (aph |-> bus.ad[1:0] == 2'h0 &&
    bus.cbe inside {`CMD_MEM_RD, `CMD_MEM_WR, `CMD_CFG_RD, `CMD_CFG_WR})
    else $error("bad address phase");
  chk_cfg_answer: assert property (s_cfg_go |-> ##[1:12] !bus.devsel_n)
    else $error("config not answered");
  chk_no_answer: assert property (s_host_go and !idsel |=> d_oe_n.devsel_n [*8])
    else $error("device answered unselected");
  chk_one_data: assert property (aph |-> ##8 (bus.frame_n && !bus.irdy_n))
    else $error("frame not ending at one data phase");
  chk_be_stable: assert property (rise && !bus.irdy_n && bus.trdy_n |-> ##8 (bus.irdy_n || bus.cbe == $past(bus.cbe, 8)))
    else $error("enables changed in data phase");
  chk_ready_sel: assert property (rise && !bus.trdy_n |-> !bus.devsel_n)
    else $error("ready without select");
  chk_grant_first: assert property (s_dev_go |-> !$past(gnt_n, 8) && !$past(req_n, 8) && $past(bus.frame_n, 8))
    else $error("device started without grant");
endmodule: pci_link_sva

// file: verification/pci_bus_interface_test.sv
`timescale 1ns/1ps
module pci_bus_interface_test;
  import pci_pkg::*;
  logic        i_mclk;            // Local clock, 100 ns
  logic        i_rst_n;           // Reset, active low
  logic        d_valid, d_write;  // Device job request
  logic [31:0] d_addr, d_data;    // Device job address, data
  logic [3:0]  d_be;              // Device job lanes
  logic        d_ready, d_done;   // Device slot free, job done
  logic        d_abort;           // Device job aborted
  logic [31:0] d_rdata;           // Device read data
  logic        h_valid, h_write;  // Host command request
  logic        h_cfg;             // Host command is config
  logic [31:0] h_addr, h_data;    // Host command address, data
  logic [3:0]  h_be;              // Host command lanes
  logic        h_ready, h_done;   // Host slot free, job done
  logic        h_abort;           // Host job aborted
  logic [31:0] h_rdata;           // Host read data
  logic [31:0] xfer_ad;           // Lanes at the last transfer
  logic [3:0]  xfer_be;           // Enables at the last transfer
  logic        pclk_q;            // Link clock one cycle ago
  int          n_mismatch;        // Mismatches found
  int          num_checks;        // Comparisons made

  pci_link_if link ();
  pci_dev_end pci_dev_end_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link.dev), .i_req_valid(d_valid),
    .i_req_write(d_write), .i_req_addr(d_addr), .i_req_be(d_be), .i_req_data(d_data), .o_req_ready(d_ready),
    .o_rsp_valid(d_done), .o_rsp_data(d_rdata), .o_rsp_abort(d_abort));
  pci_host_end pci_host_end_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link.host), .i_cmd_valid(h_valid),
    .i_cmd_cfg(h_cfg), .i_cmd_write(h_write), .i_cmd_addr(h_addr), .i_cmd_be(h_be), .i_cmd_data(h_data),
    .o_cmd_ready(h_ready), .o_done_valid(h_done), .o_done_data(h_rdata), .o_done_abort(h_abort));
  pci_link_sva pci_link_sva_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .pclk(link.pclk), .prst_n(link.prst_n),
    .idsel(link.idsel), .req_n(link.req_n), .gnt_n(link.gnt_n), .bus(link.bus), .h_oe_n(link.h_oe_n),
    .d_oe_n(link.d_oe_n));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // Catch lanes at each completed transfer, sampled on the link rise
  always @(posedge i_mclk) begin
    pclk_q <= link.pclk;
    if (link.pclk && !pclk_q && !link.bus.trdy_n && !link.bus.irdy_n) begin
      xfer_ad <= link.bus.ad;
      xfer_be <= link.bus.cbe;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask: check

  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask: final_report

  function automatic logic flag(input bit dev, done);
    if (done) return dev ? d_done : h_done;
    return dev ? d_ready : h_ready;
  endfunction: flag

  // Bounded wait on a ready or done flag; a hang ends the run
  task automatic wait_flag(input bit dev, done, input logic lvl);
    int n;
    n = 0;
    while (flag(dev, done) !== lvl) begin
      @(posedge i_mclk);
      #1;
      n++;
      if (n > 900) begin
        check("wait bound", 32'h0, 32'h1);
        final_report();
      end
    end
  endtask: wait_flag

  // One job at either end: held until taken, then the answer checked
  task automatic job(input bit dev, cfg, wr, input logic [31:0] a, input logic [3:0] be,
                     input logic [31:0] d, exp, input logic ab);
    wait_flag(dev, 1'b0, 1'b1);
    @(posedge i_mclk);
    if (dev) begin
      d_write <= wr;
      d_addr  <= a;
      d_be    <= be;
      d_data  <= d;
      d_valid <= 1'b1;
    end else begin
      h_cfg   <= cfg;
      h_write <= wr;
      h_addr  <= a;
      h_be    <= be;
      h_data  <= d;
      h_valid <= 1'b1;
    end
    wait_flag(dev, 1'b0, 1'b0);
    @(posedge i_mclk);
    if (dev) d_valid <= 1'b0;
    else h_valid <= 1'b0;
    wait_flag(dev, 1'b1, 1'b1);
    if (!wr) check("read data", (dev ? d_rdata : h_rdata), exp);
    check("abort", {31'h0, (dev ? d_abort : h_abort)}, {31'h0, ab});
  endtask: job

  initial begin
    {i_rst_n, d_valid, d_write, h_valid, h_cfg, h_write} = 6'h00;
    {d_addr, d_data, h_addr, h_data} = 128'h0;
    {d_be, h_be} = 8'h00;
    repeat (10) @(posedge i_mclk);
    check("idle lanes", link.bus.ad, 32'hFFFFFFFF);
    check("idle controls", {23'h0, link.bus[8:0]}, 32'h000001FF);
    i_rst_n <= 1'b1;
    job(1'b0, 1'b1, 1'b1, 32'h0000000C, 4'hF, 32'h11223344, 32'h0, 1'b0);
    check("write lanes", xfer_ad, 32'h11223344);
    check("write enables", {28'h0, xfer_be}, 32'h0);
    job(1'b0, 1'b1, 1'b1, 32'h0000000C, 4'h6, 32'hAABBCCDD, 32'h0, 1'b0);
    check("partial enables", {28'h0, xfer_be}, 32'h00000009);
    job(1'b0, 1'b1, 1'b0, 32'h0000000C, 4'hF, 32'h0, 32'h11BBCC44, 1'b0);
    job(1'b0, 1'b0, 1'b0, 32'h00000000, 4'hF, 32'h0, 32'h0, 1'b1);
    fork
      job(1'b1, 1'b0, 1'b1, 32'h0000003C, 4'hF, 32'hCAFE0001, 32'h0, 1'b0);
      job(1'b0, 1'b1, 1'b0, 32'h0000000C, 4'hF, 32'h0, 32'h11BBCC44, 1'b0);
    join
    job(1'b1, 1'b0, 1'b1, 32'h0000003C, 4'h8, 32'h55000000, 32'h0, 1'b0);
    check("device lanes", xfer_ad, 32'h55000000);
    job(1'b1, 1'b0, 1'b0, 32'h0000003C, 4'hF, 32'h0, 32'h55FE0001, 1'b0);
    final_report();
  end
endmodule: pci_bus_interface_test
